// [include/ebra_map.vh]
// Register offsets, field positions, reset values and timing counts of the bus arbiter
`ifndef EBRA_MAP_VH
`define EBRA_MAP_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EBRA_CTRL_OFS 4'h0
`define EBRA_STAT_OFS 4'h4
`define EBRA_WCNT_OFS 4'h8
// ****************************************************************
// Control register fields
// ****************************************************************
`define EBRA_CTRL_MEMORY_CYCLE_WAIT_COUNT_LSB 0
`define EBRA_CTRL_MEMORY_CYCLE_WAIT_COUNT_MSB 3
`define EBRA_CTRL_RWDLY_BIT 4
`define EBRA_CTRL_MUX_BIT 5
`define EBRA_CTRL_TRI_BIT 6
`define EBRA_CTRL_ARB_BIT 7
`define EBRA_CTRL_RST 8'h80
// ****************************************************************
// Status register fields
// ****************************************************************
`define EBRA_STAT_STATE_LSB 0
`define EBRA_STAT_STATE_MSB 3
`define EBRA_STAT_GRANT_BIT 4
`define EBRA_STAT_BUS_REGAIN_REQUEST_OUT_BIT 5
`define EBRA_STAT_RDY_BIT 6
`define EBRA_STAT_HOLD_BIT 7
// ****************************************************************
// Bus answers and timing
// ****************************************************************
`define EBRA_RESP_OKAY 2'h0
`define EBRA_RESP_SLVERR 2'h2
`define EBRA_MUX_WAITS 1
`define EBRA_TRI_WAITS 1
`define EBRA_MCLK_PER_OCLK 2
`endif

// [rtl/ebra_arbiter.v]
// External bus cycle termination, wait states and hold arbitration
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "ebra_map.vh"

// What this block does
// R1 - Ready sampled high adds one ready wait state and samples again.
// R2 - Ready sampled low ends the running external bus cycle.
// R3 - Slave may drop ready after the rising command strobe edge.
// R4 - Unsynchronised ready must stay low at least two clock periods plus 14 ns.
// R5 - Asynchronous ready passes a synchroniser before use.
// R6 - Programmed memory cycle wait states precede the ready sampling point.
// R7 - Command strobe falling edge position depends on read/write delay option.
// R8 - Multiplexed mode adds a multiplex wait, optionally a turnaround wait.
// R9 - Multiplexed with turnaround wait gives two output-clock cycles gap.
// R10 - Demultiplexed without turnaround wait lets next cycle start at once.
// R11 - Running cycle completes before hold acknowledge is given.
// R12 - Released chip selects are undriven, held high by pull-ups.
// R13 - Regain starts only when hold request goes inactive high.
// R14 - Bus request output asserted by last permitted clock point.
// R15 - External master may return the bus without our bus request.
// R16 - Grant and request outputs change and hold samples on output clock.
// R17 - After cycle ends, float bus outputs then assert grant.
// R18 - On regain drop grant and request, drive bus, then start cycles.
module ebra_arbiter (
    input wire mclk,
    input wire srst,
    // AXI4-Lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Internal cycle requests
    input wire cyc_req,
    input wire cyc_write,
    input wire [4:0] cyc_cs,
    output reg cyc_done,
    // Pins
    input wire ready_n,
    input wire hold_req_n,
    output reg system_clock_output,
    output reg bus_grant_ack_out,
    output reg bus_regain_request_out_n,
    output reg [4:0] chip_select_out_n,
    output reg chip_select_oe,
    output reg ale_out,
    output reg read_cmd_n,
    output reg write_cmd_n,
    output reg bus_oe
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_ADDR = 4'h1;
    localparam [3:0] ST_MEMORY_CYCLE_WAIT_COUNT = 4'h2;
    localparam [3:0] ST_CMD = 4'h3;
    localparam [3:0] ST_MUXW = 4'h4;
    localparam [3:0] ST_TRIW = 4'h5;
    localparam [3:0] ST_FLOAT = 4'h6;
    localparam [3:0] ST_HELD = 4'h7;
    localparam [3:0] ST_REGAIN = 4'h8;

    // ****************************************************************
    // Pin synchronisers and output clock
    // ****************************************************************
    wire [1:0] pins_s;
    wire ready_s_n = pins_s[0];
    wire hold_s_n = pins_s[1];

    ebra_sync2 #(.W(2), .INIT(2'h3)) u_sync (
        .mclk(mclk),
        .srst(srst),
        .async_in({hold_req_n, ready_n}), // R5
        .sync_out(pins_s)
    );

    // Output clock runs at half mclk; state steps on its falling edge only
    reg phase_q;
    wire tick = phase_q;

    always @(posedge mclk) begin
        if (srst) begin
            phase_q <= 1'b0;
            system_clock_output <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
            system_clock_output <= ~phase_q;
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    reg [7:0] ctrl_q;
    wire [3:0] memory_cycle_wait_count_cfg = ctrl_q[`EBRA_CTRL_MEMORY_CYCLE_WAIT_COUNT_MSB:`EBRA_CTRL_MEMORY_CYCLE_WAIT_COUNT_LSB];
    wire rw_delay = ctrl_q[`EBRA_CTRL_RWDLY_BIT];
    wire mux_mode = ctrl_q[`EBRA_CTRL_MUX_BIT];
    wire tri_wait = ctrl_q[`EBRA_CTRL_TRI_BIT];
    wire arb_en = ctrl_q[`EBRA_CTRL_ARB_BIT];

    // ****************************************************************
    // Bus cycle and arbitration sequencer
    // ****************************************************************
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [3:0] wcnt_q;
    reg cyc_wr_q;
    reg [4:0] cs_q;
    reg [15:0] rdy_waits_q;

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (arb_en && !hold_s_n)
                    state_d = ST_FLOAT; // R11 R16
                else if (cyc_req)
                    state_d = ST_ADDR;
            end
            ST_ADDR: state_d = (memory_cycle_wait_count_cfg != 4'h0) ? ST_MEMORY_CYCLE_WAIT_COUNT : ST_CMD; // R6
            ST_MEMORY_CYCLE_WAIT_COUNT: state_d = (wcnt_q == 4'h1) ? ST_CMD : ST_MEMORY_CYCLE_WAIT_COUNT; // R6
            ST_CMD: begin
                if (!ready_s_n) begin // R2
                    if (mux_mode)
                        state_d = ST_MUXW; // R8
                    else if (tri_wait)
                        state_d = ST_TRIW;
                    else
                        state_d = ST_IDLE; // R10
                end
            end
            ST_MUXW: state_d = tri_wait ? ST_TRIW : ST_IDLE; // R8 R9
            ST_TRIW: state_d = ST_IDLE;
            ST_FLOAT: state_d = ST_HELD; // R17
            ST_HELD: state_d = hold_s_n ? ST_REGAIN : ST_HELD; // R13 R15
            ST_REGAIN: state_d = ST_IDLE; // R18
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            wcnt_q <= 4'h0;
            cyc_wr_q <= 1'b0;
            cs_q <= 5'h1F;
            cyc_done <= 1'b0;
            rdy_waits_q <= 16'h0000;
        end else begin
            cyc_done <= 1'b0;
            if (tick) begin
                state_q <= state_d;
                if (state_q == ST_IDLE && state_d == ST_ADDR) begin
                    cyc_wr_q <= cyc_write;
                    cs_q <= ~cyc_cs;
                end
                if (state_q == ST_ADDR)
                    wcnt_q <= memory_cycle_wait_count_cfg;
                else if (state_q == ST_MEMORY_CYCLE_WAIT_COUNT)
                    wcnt_q <= wcnt_q - 4'h1;
                if (state_q == ST_CMD && ready_s_n)
                    rdy_waits_q <= rdy_waits_q + 16'h0001; // R1
                if (state_q == ST_CMD && !ready_s_n)
                    cyc_done <= 1'b1; // R2
            end
        end
    end

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    // Delayed strobe falls one mclk late, then stays low through ready waits
    // so a slave that drops ready on the rising strobe is never cut short
    wire in_cmd = (state_q == ST_CMD);
    wire strobe_on = in_cmd && (!rw_delay || phase_q || !(read_cmd_n && write_cmd_n)); // R7
    wire driving = (state_q != ST_FLOAT) && (state_q != ST_HELD);

    always @(posedge mclk) begin
        if (srst) begin
            ale_out <= 1'b0;
            read_cmd_n <= 1'b1;
            write_cmd_n <= 1'b1;
            chip_select_out_n <= 5'h1F;
            chip_select_oe <= 1'b1;
            bus_oe <= 1'b1;
            bus_grant_ack_out <= 1'b0;
            bus_regain_request_out_n <= 1'b1;
        end else begin
            ale_out <= (state_q == ST_ADDR) && !phase_q;
            read_cmd_n <= ~(strobe_on && !cyc_wr_q);
            write_cmd_n <= ~(strobe_on && cyc_wr_q);
            chip_select_out_n <= (state_q == ST_IDLE || !driving) ? 5'h1F : cs_q;
            chip_select_oe <= driving; // R12
            bus_oe <= driving; // R17
            if (tick) begin
                // Grant follows the float step by one output clock
                bus_grant_ack_out <= (state_d == ST_HELD); // R16 R17 R18
                bus_regain_request_out_n <= ~(state_d == ST_HELD && cyc_req); // R14 R18
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    reg aw_got_q;
    reg w_got_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_got_q || aw_fire;
    wire w_have = w_got_q || w_fire;
    wire [3:0] wa = aw_fire ? s_axi_awaddr : awaddr_q;
    wire [31:0] wd = w_fire ? s_axi_wdata : wdata_q;
    wire [3:0] ws = w_fire ? s_axi_wstrb : wstrb_q;
    wire do_write = aw_have && w_have && !s_axi_bvalid;

    always @(posedge mclk) begin
        if (srst) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EBRA_RESP_OKAY;
            ctrl_q <= `EBRA_CTRL_RST;
        end else begin
            if (aw_fire)
                awaddr_q <= s_axi_awaddr;
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wa == `EBRA_CTRL_OFS) begin
                    s_axi_bresp <= `EBRA_RESP_OKAY;
                    if (ws[0])
                        ctrl_q <= wd[7:0];
                end else if (wa == `EBRA_STAT_OFS || wa == `EBRA_WCNT_OFS) begin
                    s_axi_bresp <= `EBRA_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `EBRA_RESP_SLVERR;
                end
            end else begin
                if (aw_fire)
                    aw_got_q <= 1'b1;
                if (w_fire)
                    w_got_q <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_awready <= !s_axi_awready && !aw_have && !s_axi_bvalid;
            s_axi_wready <= !s_axi_wready && !w_have && !s_axi_bvalid;
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    wire ar_fire = s_axi_arvalid && s_axi_arready;

    always @(posedge mclk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `EBRA_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !ar_fire;
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `EBRA_RESP_OKAY;
                case (s_axi_araddr)
                    `EBRA_CTRL_OFS: s_axi_rdata <= {24'h000000, ctrl_q};
                    `EBRA_STAT_OFS: s_axi_rdata <= {24'h000000, !hold_s_n, !ready_s_n,
                        !bus_regain_request_out_n, bus_grant_ack_out, state_q};
                    `EBRA_WCNT_OFS: s_axi_rdata <= {16'h0000, rdy_waits_q};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `EBRA_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// [rtl/ebra_sync2.v]
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module ebra_sync2 #(
    parameter W = 2,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    input wire mclk,
    input wire srst,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge mclk) begin
        if (srst) begin
            meta_q <= INIT;
            sync_out <= INIT;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// [testbench/ebra_chk.sv]
// Concurrent checks on the arbiter pins
`timescale 1ns/1ps
module ebra_chk (
    input wire mclk,
    input wire srst,
    input wire cyc_req,
    input wire cyc_done,
    input wire ready_n,
    input wire hold_req_n,
    input wire system_clock_output,
    input wire bus_grant_ack_out,
    input wire bus_regain_request_out_n,
    input wire chip_select_oe,
    input wire ale_out,
    input wire read_cmd_n,
    input wire write_cmd_n,
    input wire bus_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    hold_float_a: assert property (bus_grant_ack_out |-> !bus_oe && !chip_select_oe)
        else $error("bus driven while granted");
    hold_quiet_a: assert property (bus_grant_ack_out |-> read_cmd_n && write_cmd_n && !ale_out)
        else $error("cycle runs while granted");
    float_first_a: assert property ($rose(bus_grant_ack_out) |-> !$past(bus_oe))
        else $error("grant before bus floated");
    done_strobe_a: assert property (cyc_done |-> !($past(read_cmd_n) && $past(write_cmd_n)))
        else $error("cycle ended without a strobe");
    ready_wait_a: assert property (ready_n [*5] |-> !cyc_done)
        else $error("cycle ended while ready high");
    oclk_half_a: assert property (!$past(srst) |->
        system_clock_output != $past(system_clock_output))
        else $error("output clock not half rate");
    pins_oclk_a: assert property ($changed(bus_grant_ack_out) ||
        $changed(bus_regain_request_out_n) |-> !system_clock_output)
        else $error("grant or request off output clock");
    regain_hold_a: assert property ($fell(bus_grant_ack_out) |-> $past(hold_req_n, 3))
        else $error("bus regained while hold low");
    bus_regain_request_out_held_a: assert property (!bus_grant_ack_out |-> bus_regain_request_out_n)
        else $error("request outside hold");
    bus_regain_request_out_want_a: assert property ((bus_grant_ack_out && cyc_req) [*4] |->
        !bus_regain_request_out_n)
        else $error("request missing while held");
endmodule
bind ebra_arbiter ebra_chk u_chk (.mclk, .srst, .cyc_req, .cyc_done, .ready_n, .hold_req_n,
    .system_clock_output, .bus_grant_ack_out, .bus_regain_request_out_n, .chip_select_oe,
    .ale_out, .read_cmd_n, .write_cmd_n, .bus_oe);

// [testbench/ebra_ext_partner.sv]
// External slave with programmable ready delay, plus chip-select pull-ups
`timescale 1ns/1ps
module ebra_ext_partner (
    input wire mclk,
    input wire srst,
    input wire ale_out,
    input wire read_cmd_n,
    input wire write_cmd_n,
    input wire [4:0] chip_select_out_n,
    input wire chip_select_oe,
    input wire [7:0] ready_thr,
    output wire ready_n,
    output wire [4:0] cs_pin
);
    logic [7:0] cnt_q;
    logic act_q, ale_q, stb_q;
    assign cs_pin = chip_select_oe ? chip_select_out_n : 5'h1F;
    // Ready low from a count after address phase, kept low until the strobe rises
    assign ready_n = !(act_q && cnt_q >= ready_thr);
    always @(posedge mclk) begin
        ale_q <= ale_out;
        stb_q <= !(read_cmd_n && write_cmd_n);
        cnt_q <= cnt_q + 8'h01;
        if (srst) begin
            act_q <= 1'b0;
        end else if (ale_out && !ale_q) begin
            act_q <= 1'b1;
            cnt_q <= 8'h00;
        end else if (stb_q && read_cmd_n && write_cmd_n) begin
            act_q <= 1'b0;
        end
    end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the bus arbiter
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [1:0] r;
        logic [31:0] q;} ebra_rrow_t;
    typedef struct {logic [7:0] c; int w; logic wr;} ebra_crow_t;
    logic mclk = 0, srst = 1, cyc_req = 0, cyc_write = 0, hold_req_n = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 0, q;
    logic [4:0] cyc_cs = 5'h01, cs_seen;
    logic [7:0] thr = 0;
    logic [1:0] r;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cyc_done, ready_n;
    wire system_clock_output, bus_grant_ack_out, bus_regain_request_out_n, chip_select_oe, bus_oe;
    wire ale_out, read_cmd_n, write_cmd_n;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [4:0] chip_select_out_n, cs_pin;
    int fail_count = 0, num_checks = 0, rd_cnt, wr_cnt, dn_cnt, n, len, gap, exp_w = 0;
    ebra_rrow_t regs[7] = '{'{1'b0, 4'h0, 32'h0, 2'h0, 32'h80}, '{1'b1, 4'hC, 32'h0, 2'h2, 32'h0},
        '{1'b0, 4'hC, 32'h0, 2'h2, 32'h0}, '{1'b1, 4'h4, 32'hFF, 2'h0, 32'h0},
        '{1'b0, 4'h4, 32'h0, 2'h0, 32'h0}, '{1'b1, 4'h0, 32'hFFFFFF5A, 2'h0, 32'h0},
        '{1'b0, 4'h0, 32'h0, 2'h0, 32'h5A}};
    ebra_crow_t cyc[7] = '{'{8'h80, 0, 1'b0}, '{8'h82, 0, 1'b1}, '{8'h80, 3, 1'b0},
        '{8'h90, 1, 1'b1}, '{8'hA0, 0, 1'b0}, '{8'hE0, 0, 1'b0}, '{8'hC0, 0, 1'b1}};
    initial forever #25 mclk = ~mclk;
    ebra_arbiter dut (.mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cyc_req, .cyc_write, .cyc_cs, .cyc_done, .ready_n, .hold_req_n,
        .system_clock_output, .bus_grant_ack_out, .bus_regain_request_out_n, .chip_select_out_n,
        .chip_select_oe, .ale_out, .read_cmd_n, .write_cmd_n, .bus_oe);
    ebra_ext_partner pm (.mclk, .srst, .ale_out, .read_cmd_n, .write_cmd_n, .chip_select_out_n,
        .chip_select_oe, .ready_thr(thr), .ready_n, .cs_pin);
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t value %h expected %h", $time, seen, exp);
        end
    endtask
    task lost;
        fail_count++;
        $display("MISMATCH t=%0t wait ran out", $time);
        report_and_stop;
    endtask
    // ****************************************************************
    // Pin sampling at the edge, before the edge updates land
    // ****************************************************************
    task step;
        @(posedge mclk);
        if (read_cmd_n === 1'b0) rd_cnt++;
        if (write_cmd_n === 1'b0) wr_cnt++;
        if (cyc_done === 1'b1) dn_cnt++;
        if ((read_cmd_n & write_cmd_n) === 1'b0) cs_seen = cs_pin;
    endtask
    task wait_for(input int sel, output int cnt);
        logic [3:0] f;
        for (cnt = 1; cnt < 300; cnt++) begin
            step;
            f = {!bus_grant_ack_out, bus_grant_ack_out, cyc_done, ale_out};
            if (f[sel] === 1'b1) return;
        end
        lost;
    endtask
    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
        int k;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (k == 50) lost;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask
    task axi_rd(input logic [3:0] a, output logic [31:0] qd, output logic [1:0] rs);
        int k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge mclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (k == 50) lost;
        qd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        repeat (3) step;
        chk({bus_grant_ack_out, bus_regain_request_out_n, chip_select_out_n, chip_select_oe,
            bus_oe, ale_out, read_cmd_n, write_cmd_n}, 12'h7FB);
        $display("test reset done");
        foreach (regs[i]) begin
            if (regs[i].w) axi_wr(regs[i].a, regs[i].d, r);
            else axi_rd(regs[i].a, q, r);
            chk(r, regs[i].r);
            if (!regs[i].w) chk(q, regs[i].q);
        end
        $display("test registers done");
        // Second cycle requested back to back to measure the gap
        foreach (cyc[i]) begin
            axi_wr(4'h0, {24'h0, cyc[i].c}, r);
            thr <= 2 * (cyc[i].c[3:0] + cyc[i].w);
            cyc_write <= cyc[i].wr;
            cyc_cs <= 5'h01 << (i % 5);
            cyc_req <= 1'b1;
            wait_for(0, n);
            rd_cnt = 0;
            wr_cnt = 0;
            wait_for(1, len);
            // Synchronised ready always costs one ready wait beyond the slave delay
            chk(len, 5 + 2 * (cyc[i].c[3:0] + cyc[i].w));
            chk(cyc[i].wr ? wr_cnt : rd_cnt, 4 + 2 * cyc[i].w - cyc[i].c[4]);
            chk(cyc[i].wr ? rd_cnt : wr_cnt, 0);
            chk(cs_seen, 5'h1F ^ (5'h01 << (i % 5)));
            wait_for(0, gap);
            chk(gap, 3 + 2 * (cyc[i].c[5] + cyc[i].c[6]));
            wait_for(1, n);
            cyc_req <= 1'b0;
            exp_w += 2 * (1 + cyc[i].w);
        end
        axi_rd(4'h8, q, r);
        chk(q, exp_w);
        $display("test cycles done");
        axi_wr(4'h0, 32'h80, r);
        thr <= 8'h04;
        cyc_req <= 1'b1;
        wait_for(0, n);
        hold_req_n <= 1'b0;
        dn_cnt = 0;
        wait_for(2, n);
        chk(dn_cnt, 1);
        chk({bus_oe, chip_select_oe, cs_pin, read_cmd_n, write_cmd_n}, 9'h07F);
        repeat (6) step;
        chk({bus_grant_ack_out, bus_regain_request_out_n, dn_cnt[1:0]}, 4'h9);
        hold_req_n <= 1'b1;
        wait_for(3, n);
        // Bus is driven again one mclk after the grant drops
        step;
        chk({bus_regain_request_out_n, bus_oe, chip_select_oe}, 3'h7);
        wait_for(1, n);
        chk(dn_cnt, 2);
        cyc_req <= 1'b0;
        $display("test hold with request done");
        hold_req_n <= 1'b0;
        wait_for(2, n);
        repeat (6) step;
        chk(bus_regain_request_out_n, 1'b1);
        hold_req_n <= 1'b1;
        wait_for(3, n);
        step;
        chk(bus_oe, 1'b1);
        $display("test hold without request done");
        report_and_stop;
    end
endmodule
